// ### src/tsl_defines.vh
// Constant definitions for the triggered sample logger.
`ifndef TSL_DEFINES_VH
`define TSL_DEFINES_VH
// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define TSL_IDX_RATE_DIV 12'h6d6
`define TSL_IDX_BASE_RATE 12'h6d7
`define TSL_IDX_CAP_LEN 12'h6d8
`define TSL_IDX_CH_EN 12'h6d9
`define TSL_IDX_SRC_LO 12'h6da
`define TSL_IDX_POLICY 12'h6db
`define TSL_IDX_TRIG_SRC 12'h6dc
`define TSL_IDX_COMPARE 12'h6dd
`define TSL_IDX_EDGE 12'h6de
`define TSL_IDX_SRC_HI 12'h6df
`define TSL_IDX_THRESH 12'h6e0
`define TSL_IDX_SCALE_FAC 12'h6e1
`define TSL_IDX_SCALE_OFS 12'h6e2
`define TSL_IDX_SAMPLE_NUM 12'h6e3
`define TSL_IDX_PRETRIG 12'h6e5
`define TSL_IDX_STATE 12'h6e7
`define TSL_IDX_DATA0 12'h6e8
`define TSL_IDX_DATA3 12'h6eb
// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSL_RST_DIV 32'h0000_0001
`define TSL_RST_LEN 32'h0000_01f4
`define TSL_RST_SRC 32'h03e8_03e8
`define TSL_RST_SRC_ID 16'h03e8
`define TSL_RST_POLICY 32'h0000_0003
`define TSL_RST_COMPARE 32'h0000_0001
`define TSL_RST_EDGE 32'h0000_0001
`define TSL_RST_SCALE_FAC 32'h0000_0100
// ----------------------------------------
// Codes
// ----------------------------------------
`define TSL_POL_FREE 8'h00
`define TSL_POL_NORMAL 8'h01
`define TSL_POL_SINGLE 8'h02
`define TSL_POL_STOP 8'h03
`define TSL_CMP_AC 8'h00
`define TSL_CMP_DC 8'h01
`define TSL_CMP_MASK 8'h02
`define TSL_CH_ON 8'h01
`define TSL_STAT_INIT 8'h00
`define TSL_STAT_WAIT 8'h01
`define TSL_STAT_SAMP 8'h02
`define TSL_STAT_READY 8'h03
`define TSL_RESP_OKAY 2'b00
`define TSL_RESP_SLVERR 2'b10
`define TSL_RESP_DECERR 2'b11
// ----------------------------------------
// Arithmetic constants
// ----------------------------------------
`define TSL_AVG_SHIFT 4
`define TSL_SCALE_FRAC 8
`define TSL_S8_MAX 49'sh000_0000_0007f
`define TSL_S8_MIN -49'sh000_0000_00080
`endif

// ### src/tsl_logger.v
// Triggered sample logger: four-channel capture with trigger engine and AXI4-Lite registers.
// Operation
// - Four channels sample any internal parameter.
// - Channel active with source id and 0x01.
// - Capture takes capture_length sample instants; after a negative-count delay the code stores one fewer.
// - Enabled channels stored interleaved, channel order.
// - Memory reachable only through extraction registers.
// - Sample at control tick rate over divisor.
// - Undivided control rate readable, read-only.
// - Trigger source selected by parameter identifier.
// - Policy 0 free running; 3 stops sampling.
// - Policy 1 waits trigger, re-arms after capture.
// - Policy 2 captures once, then ready.
// - State reports init, wait, sampling, ready.
// - Capture data readable only when ready.
// - Stop ends run after current sampling completes.
// - Compare style AC, DC or bitmask.
// - Bitmask: only masked bits may trigger.
// - Masked 0-1 rising, 1-0 falling.
// - Edge select rising, falling or both.
// - Pretrigger count places samples before trigger.
// - Negative count delays sampling after trigger.
// - Readout adds offset, scales, rounds to s8.
// - Readout starts at index relative to trigger.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tsl_defines.vh"
module tsl_logger #(
  parameter AW = 15,
  parameter BASE_RATE = 32'd9920
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data.
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read.
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Control interrupt tick, one cycle per control period.
  input wire control_tick,
  // Parameter selectors and the values they return.
  output wire [15:0] chan_src_id_0,
  output wire [15:0] chan_src_id_1,
  output wire [15:0] chan_src_id_2,
  output wire [15:0] chan_src_id_3,
  output wire [15:0] trig_src_id,
  input wire [31:0] chan_value_0,
  input wire [31:0] chan_value_1,
  input wire [31:0] chan_value_2,
  input wire [31:0] chan_value_3,
  input wire [31:0] trig_value
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Counts enabled channels below channel ch.
  function [2:0] rank;
    input [3:0] en;
    input [2:0] ch;
    integer k;
    begin
      rank = 3'd0;
      for (k = 0; k < 4; k = k + 1) begin
        if (k < ch && en[k]) begin
          rank = rank + 3'd1;
        end
      end
    end
  endfunction
  // Merges write data into a register under byte strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[8*b +: 8] = nw[8*b +: 8];
        end
      end
    end
  endfunction
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_INIT = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_SAMP = 3'd2;
  localparam S_READY = 3'd3;
  localparam S_DELAY = 3'd4;
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [31:0] div_q, len_q, en_q, srclo_q, srchi_q, pol_q, tsrc_q, cmp_q;
  reg [31:0] edge_q, thr_q, sfac_q, sofs_q, snum_q, pre_q;
  reg [2:0] st_q;                    // Capture state.
  reg have_q;                        // A finished capture exists.
  reg free_q;                        // Run is free running.
  reg pol_wr_q;                      // Policy was written last cycle.
  reg [15:0] tick_cnt_q;             // Control ticks since last sample.
  reg samp_q;                        // One-cycle sample instant pulse.
  reg [AW-1:0] wptr_q;               // Next memory word to write.
  reg [AW-1:0] base_q;               // Word of readout index zero: trigger instant, first instant after delay, or oldest.
  reg [15:0] fill_q;                 // Instants stored while waiting.
  reg [15:0] cnt_q;                  // Delay instants since trigger, then instants counted since capture start.
  reg [2:0] seq_q;                   // Channel being stored; 4 means idle.
  reg [31:0] cap_q [0:3];            // Values latched at the instant.
  reg [31:0] mem_q [0:(1<<AW)-1];    // Capture memory.
  reg signed [31:0] prev_q;          // Compared value at last instant.
  reg [31:0] prev_raw_q;             // Raw trigger value at last instant.
  reg prev_ok_q;                     // prev_q holds a real sample.
  reg signed [31:0] avg_q;           // Running average for AC compare.
  reg [15:0] ridx_q [0:3];           // Per-channel readout index.
  // Bus handshake state.
  reg aw_have_q, w_have_q;
  reg [15:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] rst_q;                   // Read pipeline stage.
  reg [1:0] rch_q;                   // Channel of the pending data read.
  reg [AW-1:0] raddr_q;
  reg signed [31:0] rmem_q;
  integer i;
  integer j;                         // Loop index of the read path only.
  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire [3:0] ch_en;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_en
      assign ch_en[g] = (en_q[8*g +: 8] == `TSL_CH_ON);
    end
  endgenerate
  wire [2:0] nch = rank(ch_en, 3'd4);
  wire [7:0] state_code = (st_q == S_DELAY) ? `TSL_STAT_WAIT : {5'd0, st_q};
  wire signed [15:0] pre_s = pre_q[15:0];
  wire [15:0] pre_pos = pre_s[15] ? 16'd0 : pre_q[15:0];
  wire [15:0] post_n = (pre_pos < len_q[15:0]) ? len_q[15:0] - pre_pos : 16'd1;
  wire [15:0] divisor = (div_q[15:0] == 16'd0) ? 16'd1 : div_q[15:0];
  assign chan_src_id_0 = srclo_q[15:0];
  assign chan_src_id_1 = srclo_q[31:16];
  assign chan_src_id_2 = srchi_q[15:0];
  assign chan_src_id_3 = srchi_q[31:16];
  assign trig_src_id = tsrc_q[15:0];
  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Divides the control tick into one sample instant pulse.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 16'd0;
      samp_q <= 1'b0;
    end else begin
      samp_q <= 1'b0;
      if (control_tick) begin
        if (tick_cnt_q + 16'd1 >= divisor) begin
          tick_cnt_q <= 16'd0;
          samp_q <= 1'b1;
        end else begin
          tick_cnt_q <= tick_cnt_q + 16'd1;
        end
      end
    end
  end
  // ----------------------------------------
  // Trigger detection
  // ----------------------------------------
  wire signed [31:0] cur = trig_value;
  wire signed [31:0] ac_val = cur - avg_q;
  wire signed [31:0] cmp_val = (cmp_q[7:0] == `TSL_CMP_AC) ? ac_val : cur;
  wire signed [31:0] thr_s = thr_q;
  wire lvl_rise = prev_ok_q && (prev_q < thr_s) && (cmp_val >= thr_s);
  wire lvl_fall = prev_ok_q && (prev_q >= thr_s) && (cmp_val < thr_s);
  wire msk_rise = prev_ok_q && |(~prev_raw_q & trig_value & thr_q);
  wire msk_fall = prev_ok_q && |(prev_raw_q & ~trig_value & thr_q);
  wire is_mask = (cmp_q[7:0] == `TSL_CMP_MASK);
  wire rise = is_mask ? msk_rise : lvl_rise;
  wire fall = is_mask ? msk_fall : lvl_fall;
  wire trig_hit = (edge_q[0] && rise) || (edge_q[1] && fall);
  // Tracks the previous compared value and the running average.
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 32'sh0;
      prev_raw_q <= 32'h0;
      prev_ok_q <= 1'b0;
      avg_q <= 32'sh0;
    end else if (st_q == S_INIT || st_q == S_READY) begin
      prev_ok_q <= 1'b0;
    end else if (samp_q) begin
      prev_q <= cmp_val;
      prev_raw_q <= trig_value;
      prev_ok_q <= 1'b1;
      avg_q <= avg_q + (ac_val >>> `TSL_AVG_SHIFT);
    end
  end
  // ----------------------------------------
  // Capture control and storage
  // ----------------------------------------
  wire storing = (st_q == S_WAIT) || (st_q == S_SAMP);
  wire stop_req = (pol_q[7:0] == `TSL_POL_STOP);
  // Runs the capture state machine and the interleaving store sequencer.
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_INIT;
      have_q <= 1'b0;
      free_q <= 1'b0;
      wptr_q <= {AW{1'b0}};
      base_q <= {AW{1'b0}};
      fill_q <= 16'd0;
      cnt_q <= 16'd0;
      seq_q <= 3'd4;
      for (i = 0; i < 4; i = i + 1) begin
        cap_q[i] <= 32'h0;
      end
    end else begin
      // Store sequencer: one channel per cycle over all four, storing only enabled ones, in channel order.
      if (samp_q && storing) begin
        cap_q[0] <= chan_value_0;
        cap_q[1] <= chan_value_1;
        cap_q[2] <= chan_value_2;
        cap_q[3] <= chan_value_3;
        seq_q <= 3'd0;
      end else if (seq_q != 3'd4) begin
        if (ch_en[seq_q[1:0]]) begin
          mem_q[wptr_q] <= cap_q[seq_q[1:0]];
          wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        seq_q <= seq_q + 3'd1;
      end
      case (st_q)
        S_INIT, S_READY: begin
          // A run starts only on a policy write other than stop.
          if (pol_wr_q && !stop_req) begin
            fill_q <= 16'd0;
            cnt_q <= 16'd0;
            have_q <= 1'b0;
            free_q <= (pol_q[7:0] == `TSL_POL_FREE);
            st_q <= (pol_q[7:0] == `TSL_POL_FREE) ? S_SAMP : S_WAIT;
          end
        end
        S_WAIT: begin
          if (stop_req) begin
            st_q <= have_q ? S_READY : S_INIT;
          end else if (samp_q) begin
            if (trig_hit && fill_q >= pre_pos) begin
              if (pre_s[15]) begin
                cnt_q <= 16'd0;
                st_q <= S_DELAY;
              end else begin
                base_q <= wptr_q;
                cnt_q <= 16'd1;
                st_q <= S_SAMP;
              end
            end else if (fill_q != 16'hffff) begin
              fill_q <= fill_q + 16'd1;
            end
          end
        end
        S_DELAY: begin
          if (stop_req) begin
            st_q <= have_q ? S_READY : S_INIT;
          end else if (samp_q) begin
            if (cnt_q + 16'd1 >= (16'd0 - pre_q[15:0])) begin
              base_q <= wptr_q;
              cnt_q <= 16'd1;
              st_q <= S_SAMP;
            end else begin
              cnt_q <= cnt_q + 16'd1;
            end
          end
        end
        S_SAMP: begin
          if (free_q) begin
            if (stop_req && seq_q == 3'd4 && !samp_q) begin
              // Oldest of the last capture_length instants becomes index zero.
              base_q <= wptr_q - len_q[AW-1:0] * nch;
              have_q <= 1'b1;
              st_q <= S_READY;
            end
          end else if (cnt_q >= post_n && seq_q == 3'd4 && !samp_q) begin
            have_q <= 1'b1;
            if (pol_q[7:0] == `TSL_POL_NORMAL) begin
              fill_q <= 16'd0;
              st_q <= S_WAIT;
            end else begin
              st_q <= S_READY;
            end
          end else if (samp_q) begin
            cnt_q <= cnt_q + 16'd1;
          end
        end
        default: begin
          st_q <= S_INIT;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Register write path
  // ----------------------------------------
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  wire [11:0] widx = awaddr_q[13:2];
  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire data_w = (awaddr_q[15:14] == 2'b00);
  // Takes address and data in either order, then writes and answers.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 16'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TSL_RESP_OKAY;
      pol_wr_q <= 1'b0;
      div_q <= `TSL_RST_DIV;
      len_q <= `TSL_RST_LEN;
      en_q <= 32'h0;
      srclo_q <= `TSL_RST_SRC;
      srchi_q <= `TSL_RST_SRC;
      pol_q <= `TSL_RST_POLICY;
      tsrc_q <= {16'h0, `TSL_RST_SRC_ID};
      cmp_q <= `TSL_RST_COMPARE;
      edge_q <= `TSL_RST_EDGE;
      thr_q <= 32'h0;
      sfac_q <= `TSL_RST_SCALE_FAC;
      sofs_q <= 32'h0;
      snum_q <= 32'h0;
      pre_q <= 32'h0;
    end else begin
      pol_wr_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `TSL_RESP_OKAY;
        case (data_w ? widx : 12'h000)
          `TSL_IDX_RATE_DIV: div_q <= merge(div_q, wdata_q, wstrb_q);
          `TSL_IDX_CAP_LEN: len_q <= merge(len_q, wdata_q, wstrb_q);
          `TSL_IDX_CH_EN: en_q <= merge(en_q, wdata_q, wstrb_q);
          `TSL_IDX_SRC_LO: srclo_q <= merge(srclo_q, wdata_q, wstrb_q);
          `TSL_IDX_SRC_HI: srchi_q <= merge(srchi_q, wdata_q, wstrb_q);
          `TSL_IDX_POLICY: begin
            pol_q <= merge(pol_q, wdata_q, wstrb_q);
            pol_wr_q <= wstrb_q[0];
          end
          `TSL_IDX_TRIG_SRC: tsrc_q <= merge(tsrc_q, wdata_q, wstrb_q);
          `TSL_IDX_COMPARE: cmp_q <= merge(cmp_q, wdata_q, wstrb_q);
          `TSL_IDX_EDGE: edge_q <= merge(edge_q, wdata_q, wstrb_q);
          `TSL_IDX_THRESH: thr_q <= merge(thr_q, wdata_q, wstrb_q);
          `TSL_IDX_SCALE_FAC: sfac_q <= merge(sfac_q, wdata_q, wstrb_q);
          `TSL_IDX_SCALE_OFS: sofs_q <= merge(sofs_q, wdata_q, wstrb_q);
          `TSL_IDX_SAMPLE_NUM: snum_q <= merge(snum_q, wdata_q, wstrb_q);
          `TSL_IDX_PRETRIG: pre_q <= merge(pre_q, wdata_q, wstrb_q);
          `TSL_IDX_BASE_RATE, `TSL_IDX_STATE: s_axi_bresp <= `TSL_RESP_SLVERR;
          default: begin
            if (data_w && widx >= `TSL_IDX_DATA0 && widx <= `TSL_IDX_DATA3) begin
              s_axi_bresp <= `TSL_RESP_SLVERR;
            end else begin
              s_axi_bresp <= `TSL_RESP_DECERR;
            end
          end
        endcase
      end
    end
  end
  // ----------------------------------------
  // Register read path and scaled readout
  // ----------------------------------------
  assign s_axi_arready = (rst_q == 2'd0) && !s_axi_rvalid;
  wire [11:0] ridx = s_axi_araddr[13:2];
  wire data_r = (s_axi_araddr[15:14] == 2'b00);
  wire is_dat = data_r && ridx >= `TSL_IDX_DATA0 && ridx <= `TSL_IDX_DATA3;
  wire [1:0] ach = ridx[1:0];
  wire signed [17:0] sidx = $signed(snum_q[15:0]) + $signed({2'b00, ridx_q[ach]});
  wire signed [20:0] woff = sidx * $signed({1'b0, nch});
  wire [AW-1:0] rd_word = base_q + woff[AW-1:0] + {{(AW-3){1'b0}}, rank(ch_en, {1'b0, ach})};
  wire signed [32:0] ofs_sum = {rmem_q[31], rmem_q} + {sofs_q[31], sofs_q};
  wire signed [48:0] prod = ofs_sum * $signed(sfac_q[15:0]);
  wire signed [48:0] rnd = (prod + (49'sd1 <<< (`TSL_SCALE_FRAC - 1))) >>> `TSL_SCALE_FRAC;
  wire [7:0] sat = (rnd > `TSL_S8_MAX) ? 8'h7f : (rnd < `TSL_S8_MIN) ? 8'h80 : rnd[7:0];
  // Answers plain reads in one cycle and capture data through a memory pipeline.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= 2'd0;
      rch_q <= 2'd0;
      raddr_q <= {AW{1'b0}};
      rmem_q <= 32'sh0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TSL_RESP_OKAY;
      for (j = 0; j < 4; j = j + 1) begin
        ridx_q[j] <= 16'd0;
      end
    end else begin
      if (do_wr && data_w && widx == `TSL_IDX_SAMPLE_NUM) begin
        for (j = 0; j < 4; j = j + 1) begin
          ridx_q[j] <= 16'd0;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rst_q == 2'd1) begin
        rmem_q <= mem_q[raddr_q];
        rst_q <= 2'd2;
      end else if (rst_q == 2'd2) begin
        s_axi_rdata <= {{24{sat[7]}}, sat};
        s_axi_rresp <= `TSL_RESP_OKAY;
        s_axi_rvalid <= 1'b1;
        ridx_q[rch_q] <= ridx_q[rch_q] + 16'd1;
        rst_q <= 2'd0;
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rresp <= `TSL_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (is_dat && st_q == S_READY) begin
          raddr_q <= rd_word;
          rch_q <= ach;
          rst_q <= 2'd1;
        end else begin
          s_axi_rvalid <= 1'b1;
          case (data_r ? ridx : 12'h000)
            `TSL_IDX_RATE_DIV: s_axi_rdata <= {16'h0, div_q[15:0]};
            `TSL_IDX_BASE_RATE: s_axi_rdata <= BASE_RATE;
            `TSL_IDX_CAP_LEN: s_axi_rdata <= {16'h0, len_q[15:0]};
            `TSL_IDX_CH_EN: s_axi_rdata <= en_q;
            `TSL_IDX_SRC_LO: s_axi_rdata <= srclo_q;
            `TSL_IDX_SRC_HI: s_axi_rdata <= srchi_q;
            `TSL_IDX_POLICY: s_axi_rdata <= {24'h0, pol_q[7:0]};
            `TSL_IDX_TRIG_SRC: s_axi_rdata <= {16'h0, tsrc_q[15:0]};
            `TSL_IDX_COMPARE: s_axi_rdata <= {24'h0, cmp_q[7:0]};
            `TSL_IDX_EDGE: s_axi_rdata <= {24'h0, edge_q[7:0]};
            `TSL_IDX_THRESH: s_axi_rdata <= thr_q;
            `TSL_IDX_SCALE_FAC: s_axi_rdata <= {16'h0, sfac_q[15:0]};
            `TSL_IDX_SCALE_OFS: s_axi_rdata <= sofs_q;
            `TSL_IDX_SAMPLE_NUM: s_axi_rdata <= {16'h0, snum_q[15:0]};
            `TSL_IDX_PRETRIG: s_axi_rdata <= {16'h0, pre_q[15:0]};
            `TSL_IDX_STATE: s_axi_rdata <= {24'h0, state_code};
            default: begin
              // Capture data outside the ready state is refused.
              s_axi_rresp <= is_dat ? `TSL_RESP_SLVERR : `TSL_RESP_DECERR;
            end
          endcase
        end
      end
    end
  end
endmodule

// ### bench/tsl_monitor.sv
// Concurrent checks on the ports of the triggered sample logger.
`timescale 1ns/1ps
`include "tsl_defines.vh"
module tsl_monitor (
  // Clock and reset.
  input logic aclk,
  input logic aresetn,
  // Register bus handshakes.
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rready,
  // Parameter selectors.
  input logic [15:0] chan_src_id_0,
  input logic [15:0] trig_src_id
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read response late");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response pending after reset");
  src_default_a: assert property ($rose(aresetn) |-> chan_src_id_0 == `TSL_RST_SRC_ID
    && trig_src_id == `TSL_RST_SRC_ID) else $error("source selector default wrong");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `TSL_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read returned data");
  // Main scenarios reached.
  cover property (s_axi_rvalid && s_axi_rresp == `TSL_RESP_SLVERR);
  cover property (s_axi_bvalid && s_axi_bresp == `TSL_RESP_DECERR);
  cover property (s_axi_rvalid && s_axi_rdata == 32'h0000_000e);
endmodule
bind tsl_logger tsl_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready, .chan_src_id_0,
  .trig_src_id);

// ### bench/tb.sv
// Register-level testbench for the triggered sample logger.
`timescale 1ns/1ps
`include "tsl_defines.vh"
module tb;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, tick = 0;
  logic [15:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, tv = 32'hffff_ffff;
  logic [2:0] cnt = 0;
  wire awr, wr_rdy, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [15:0] sid1, sid2, sid3;
  integer failures = 0, n_compared = 0;
  always #12.5 aclk = ~aclk;
  // Control tick every eight cycles.
  always @(posedge aclk) begin
    cnt <= cnt + 3'h1;
    tick <= (cnt == 3'h7);
  end
  tsl_logger uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .control_tick(tick),
    .chan_src_id_0(), .chan_src_id_1(sid1), .chan_src_id_2(sid2), .chan_src_id_3(sid3),
    .trig_src_id(),
    .chan_value_0(tv), .chan_value_1(tv), .chan_value_2(tv), .chan_value_3(tv),
    .trig_value(tv));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Register write; both items offered together, each released when taken.
  task automatic wr(input [11:0] i, input [31:0] d, input [1:0] er);
    integer n;
    logic a, w;
    a = 0;
    w = 0;
    awa <= {2'b00, i, 2'b00};
    wd <= d;
    awv <= 1;
    wv <= 1;
    for (n = 0; n < 50 && !(a && w); n++) begin
      @(posedge aclk);
      if (awr) begin a = 1; awv <= 0; end
      if (wr_rdy) begin w = 1; wv <= 0; end
    end
    n = 0;
    do begin @(posedge aclk); n++; end while (!bv && n < 50);
    chk({bv, br}, {1'b1, er});
  endtask
  // Register read returning data and response.
  task automatic rd(input [11:0] i, output [31:0] d, output [1:0] r);
    integer n;
    ara <= {2'b00, i, 2'b00};
    arv <= 1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!arr && n < 50);
    arv <= 0;
    n = 0;
    do begin @(posedge aclk); n++; end while (!rv && n < 50);
    d = rv ? rdat : 32'hdead_beef;
    r = rr;
  endtask
  // Read and compare data and response.
  task automatic rc(input [11:0] i, input [31:0] e, input [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Polls the capture state until it shows the expected code.
  task automatic poll(input [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    integer n;
    n = 0;
    do begin rd(`TSL_IDX_STATE, d, r); n++; end while (d !== e && n < 300);
    chk(d, e);
  endtask
  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(`TSL_IDX_RATE_DIV, `TSL_RST_DIV, `TSL_RESP_OKAY);
    rc(`TSL_IDX_BASE_RATE, 32'd9920, `TSL_RESP_OKAY);
    rc(`TSL_IDX_CAP_LEN, `TSL_RST_LEN, `TSL_RESP_OKAY);
    rc(`TSL_IDX_CH_EN, 32'h0, `TSL_RESP_OKAY);
    rc(`TSL_IDX_SRC_LO, `TSL_RST_SRC, `TSL_RESP_OKAY);
    rc(`TSL_IDX_POLICY, `TSL_RST_POLICY, `TSL_RESP_OKAY);
    rc(`TSL_IDX_COMPARE, `TSL_RST_COMPARE, `TSL_RESP_OKAY);
    rc(`TSL_IDX_EDGE, `TSL_RST_EDGE, `TSL_RESP_OKAY);
    rc(`TSL_IDX_STATE, {24'h0, `TSL_STAT_INIT}, `TSL_RESP_OKAY);
    rc(`TSL_IDX_DATA0, 32'h0, `TSL_RESP_SLVERR);
    wr(`TSL_IDX_BASE_RATE, 32'h1, `TSL_RESP_SLVERR);
    wr(12'h100, 32'h1, `TSL_RESP_DECERR);
    wr(`TSL_IDX_SRC_HI, 32'h0123_0456, `TSL_RESP_OKAY);
    chk({sid3, sid2}, 32'h0123_0456);
    chk({sid1, 16'h0}, {`TSL_RST_SRC_ID, 16'h0});
    // Single capture of four instants on channel 0, rising DC crossing of zero.
    wr(`TSL_IDX_CAP_LEN, 32'h4, `TSL_RESP_OKAY);
    wr(`TSL_IDX_CH_EN, 32'h1, `TSL_RESP_OKAY);
    wr(`TSL_IDX_THRESH, 32'h0, `TSL_RESP_OKAY);
    wr(`TSL_IDX_PRETRIG, 32'h0, `TSL_RESP_OKAY);
    wr(`TSL_IDX_SCALE_FAC, 32'h200, `TSL_RESP_OKAY);
    wr(`TSL_IDX_SCALE_OFS, 32'h2, `TSL_RESP_OKAY);
    wr(`TSL_IDX_POLICY, 32'h2, `TSL_RESP_OKAY);
    repeat (40) @(posedge aclk);
    rc(`TSL_IDX_STATE, {24'h0, `TSL_STAT_WAIT}, `TSL_RESP_OKAY);
    tv <= 32'h5;
    poll({24'h0, `TSL_STAT_READY});
    wr(`TSL_IDX_SAMPLE_NUM, 32'h0, `TSL_RESP_OKAY);
    repeat (4) rc(`TSL_IDX_DATA0, 32'h0000_000e, `TSL_RESP_OKAY);
    // Free running, then stop ends the run in the ready state.
    wr(`TSL_IDX_POLICY, 32'h0, `TSL_RESP_OKAY);
    rc(`TSL_IDX_STATE, {24'h0, `TSL_STAT_SAMP}, `TSL_RESP_OKAY);
    wr(`TSL_IDX_POLICY, 32'h3, `TSL_RESP_OKAY);
    poll({24'h0, `TSL_STAT_READY});
    // Normal policy, falling mask edge on bit 2, capture delayed by two instants.
    wr(`TSL_IDX_COMPARE, 32'h2, `TSL_RESP_OKAY);
    wr(`TSL_IDX_THRESH, 32'h4, `TSL_RESP_OKAY);
    wr(`TSL_IDX_EDGE, 32'h2, `TSL_RESP_OKAY);
    wr(`TSL_IDX_PRETRIG, 32'hffff_fffe, `TSL_RESP_OKAY);
    wr(`TSL_IDX_POLICY, 32'h1, `TSL_RESP_OKAY);
    repeat (20) @(posedge aclk);
    tv <= 32'h1;
    poll({24'h0, `TSL_STAT_SAMP});
    poll({24'h0, `TSL_STAT_WAIT});
    wr(`TSL_IDX_POLICY, 32'h3, `TSL_RESP_OKAY);
    poll({24'h0, `TSL_STAT_READY});
    wr(`TSL_IDX_SAMPLE_NUM, 32'h0, `TSL_RESP_OKAY);
    rc(`TSL_IDX_DATA0, 32'h0000_0006, `TSL_RESP_OKAY);
    complete_run;
  end
endmodule
